// file: dv/flash_bus_command_interface_tb.sv
`timescale 1ns/1ps
module flash_bus_command_interface_tb
   import flbci_pkg::*;
;
   logic        clock = 1'b0, reset = 1'b1, cmd_valid = 1'b0, vpp_ok = 1'b1;
   logic [3:0]  cmd_op = 4'h0;
   logic [18:0] cmd_addr = 19'h0, address_lines, a1;
   logic [15:0] cmd_data = 16'h0, rd, resp_data, data_lines_out, data_lines_in;
   logic        cmd_ready, resp_valid, flash_busy, powered_down, data_lines_oe;
   logic        chip_select_n, output_enable_n, write_enable_n, reset_powerdown_n;
   logic        ready_busy_n;
   int          n_mismatch = 0, total_checks = 0;
   logic [15:0] expm [int];
   always #2.5 clock = ~clock;
   flbci_host u_dut (.clock, .reset, .cmd_valid, .cmd_ready, .cmd_op, .cmd_addr, .cmd_data,
      .resp_valid, .resp_data, .flash_busy, .powered_down, .address_lines, .data_lines_out,
      .data_lines_oe, .data_lines_in, .chip_select_n, .output_enable_n, .write_enable_n,
      .reset_powerdown_n, .ready_busy_n);
   flbci_flash_model u_flash (.clock, .vpp_ok, .address_lines, .data_lines_out,
      .data_lines_oe, .chip_select_n, .output_enable_n, .write_enable_n, .reset_powerdown_n,
      .data_lines_in, .ready_busy_n);
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic give_verdict();
      if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : give_verdict
   function automatic logic [15:0] ev(logic [18:0] a);
      return expm.exists(a) ? expm[a] : 16'hffff;
   endfunction : ev
   // Request is held until taken, then the answer is picked up at its edge
   task automatic op(flbci_op_t o, logic [18:0] a, logic [15:0] d = 16'h0);
      cmd_op = o;
      cmd_addr = a;
      cmd_data = d;
      cmd_valid = 1'b1;
      do @(posedge clock); while (cmd_ready !== 1'b1);
      #1 cmd_valid = 1'b0;
      do @(posedge clock); while (resp_valid !== 1'b1);
      rd = resp_data;
      #1;
   endtask : op
   task automatic rchk(flbci_op_t o, logic [18:0] a, string n, logic [15:0] e);
      op(o, a);
      chk(n, e, rd);
   endtask : rchk
   task automatic ww(logic [18:0] a, logic [15:0] d);
      op(OP_WORD_WRITE, a, d);
      if (vpp_ok) expm[a] = ev(a) & d;
   endtask : ww
   task automatic er(logic [18:0] a);
      int sz;
      sz = a >= 19'h78000 ? 4096 : 32768;
      op(OP_BLOCK_ERASE, a);
      for (int i = 0; i < sz; i++) expm.delete((int'(a) & ~(sz - 1)) + i);
   endtask : er
   task automatic done_chk(logic [15:0] e);
      rchk(OP_READ_STATUS, 19'h0, "busy status", 16'h0000);
      chk("busy pin", 16'h1, {15'h0, flash_busy});
      for (int i = 0; i < 2000 && flash_busy !== 1'b0; i++) @(posedge clock);
      #1;
      chk("idle pin", 16'h0, {15'h0, flash_busy});
      rchk(OP_READ_STATUS, 19'h0, "final status", e);
   endtask : done_chk
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #100000;
      n_mismatch++;
      give_verdict();
   end
   initial begin
      void'($urandom(32'h66aca790));
      repeat (10) @(posedge clock);
      #1 reset = 1'b0;
      a1 = 19'($urandom % 32'h78000);
      rchk(OP_READ_ARRAY, a1, "power-up array", 16'hffff);
      vpp_ok = 1'b0;
      rchk(OP_READ_STATUS, 19'h0, "power-up status", 16'h0080);
      rchk(OP_READ_ID, 19'h0, "maker code", u_flash.MAKER_CODE);
      rchk(OP_READ_ID, 19'h1, "part code", u_flash.PART_CODE);
      ww(a1, 16'($urandom));
      done_chk(16'h00a8);
      rchk(OP_READ_ARRAY, a1, "locked word", 16'hffff);
      op(OP_CLEAR_STATUS, 19'h0);
      rchk(OP_READ_STATUS, 19'h0, "cleared status", 16'h0080);
      vpp_ok = 1'b1;
      for (int k = 0; k < 4; k++) begin
         a1 = 19'($urandom % 32'h78000);
         ww(a1, 16'($urandom));
         done_chk(16'h0080);
         rchk(OP_READ_ARRAY, a1, "written word", ev(a1));
      end
      ww(19'h78000, 16'h1234);
      done_chk(16'h0080);
      ww(19'h77fff, 16'h5678);
      done_chk(16'h0080);
      er(19'h70000 + 19'($urandom & 32'h7fff));
      done_chk(16'h0080);
      rchk(OP_READ_ARRAY, 19'h77fff, "erased top main", 16'hffff);
      rchk(OP_READ_ARRAY, 19'h78000, "kept parameter", 16'h1234);
      for (int k = 0; k < 2; k++) begin
         if (k == 0) er(19'h40000);
         else ww(19'h40005, 16'h0f0f);
         op(OP_SUSPEND, 19'h0);
         rchk(OP_READ_STATUS, 19'h0, "suspend status", 16'h0080);
         chk("suspend pin", 16'h0, {15'h0, flash_busy});
         rchk(OP_READ_ARRAY, 19'h78000, "suspend read", ev(19'h78000));
         op(OP_RESUME, 19'h0);
         done_chk(16'h0080);
      end
      rchk(OP_READ_ARRAY, 19'h40005, "resumed word", ev(19'h40005));
      er(19'h08000);
      op(OP_POWERDOWN, 19'h0);
      repeat (2) @(posedge clock);
      #1;
      chk("powered down", 16'h1, {15'h0, powered_down});
      rchk(OP_READ_STATUS, 19'h0, "wake status", 16'h0080);
      chk("wake pin", 16'h0, {15'h0, flash_busy});
      rchk(OP_READ_ARRAY, 19'h40005, "wake array", ev(19'h40005));
      reset = 1'b1;
      repeat (10) @(posedge clock);
      #1 reset = 1'b0;
      rchk(OP_READ_ARRAY, 19'h78000, "after reset", 16'h1234);
      give_verdict();
   end
endmodule : flash_bus_command_interface_tb

// file: dv/flbci_flash_model.sv
`timescale 1ns/1ps
module flbci_flash_model #(
   parameter int          BUSY_CYC   = 300,
   parameter bit          BOTTOM_BOOT = 1'b0,
   parameter int          WAKE_MIN   = 190,
   parameter int          ACC_CYC    = 20,
   // Identifier values are arbitrary
   parameter logic [15:0] MAKER_CODE = 16'h5a3c,
   parameter logic [15:0] PART_CODE  = 16'h1e2d
)(
   input  wire logic        clock,
   input  wire logic        vpp_ok,
   input  wire logic [18:0] address_lines,
   input  wire logic [15:0] data_lines_out,
   input  wire logic        data_lines_oe,
   input  wire logic        chip_select_n,
   input  wire logic        output_enable_n,
   input  wire logic        write_enable_n,
   input  wire logic        reset_powerdown_n,
   output logic      [15:0] data_lines_in,
   output logic             ready_busy_n
);
   logic [15:0] mem [int];
   logic [18:0] la, ta;
   logic [15:0] ld, td;
   logic [7:0]  sr = 8'h00;
   logic        gt = 1'b0, gs = 1'b0, kind = 1'b0, susp = 1'b0, run;
   int          mode = 0, pend = 0, bcnt = 0, abc = 0, wcnt = 0, acc = 0;
   initial data_lines_in = 16'h5555;
   assign run = bcnt != 0 && !susp;
   assign ready_busy_n = !(run || abc != 0);
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] rdval(logic [18:0] a);
      if (mode == 1) return {8'h00, !run, sr[6:0]};
      if (mode == 2) return a == 19'h0 ? MAKER_CODE : a == 19'h1 ? PART_CODE : 16'h0000;
      return mem.exists(a) ? mem[a] : 16'hffff;
   endfunction : rdval
   task automatic command();
      if (pend != 0) begin
         mode = 1;
         if (pend == 1 || ld[7:0] == 8'hd0) begin
            ta = la;
            td = ld;
            kind = pend == 2;
            bcnt = BUSY_CYC;
         end else sr = sr | 8'h30;
         pend = 0;
      end else case (ld[7:0])
         8'hff: if (!run) mode = 0;
         8'h90: if (!run) mode = 2;
         8'h70: mode = 1;
         8'h50: sr = 8'h00;
         8'h40, 8'h10: pend = 1;
         8'h20: pend = 2;
         8'hb0: susp = bcnt != 0;
         8'hd0: susp = 1'b0;
         default: ;
      endcase
   endtask : command
   // Small blocks sit at the top, or at the bottom for the bottom-boot map
   task automatic complete();
      int base, sz;
      if (!vpp_ok) sr = sr | 8'h28;
      else if (!kind) mem[ta] = (mem.exists(ta) ? mem[ta] : 16'hffff) & td;
      else begin
         sz = (BOTTOM_BOOT ? ta < 19'h08000 : ta >= 19'h78000) ? 4096 : 32768;
         base = int'(ta) & ~(sz - 1);
         for (int i = 0; i < sz; i++) mem.delete(base + i);
      end
   endtask : complete
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge write_enable_n or posedge chip_select_n)
      if (!(write_enable_n && chip_select_n)) begin
         la = address_lines;
         ld = data_lines_out;
         gt = !gt;
      end
   always @(posedge clock) begin
      abc = abc > 0 ? abc - 1 : 0;
      if (!reset_powerdown_n) begin
         if (run) abc = 8;
         bcnt = 0;
         susp = 1'b0;
         mode = 0;
         pend = 0;
         sr = 8'h00;
         wcnt = 0;
      end else if (wcnt < WAKE_MIN) wcnt++;
      if (gt != gs) begin
         gs = gt;
         if (reset_powerdown_n && wcnt >= WAKE_MIN) command();
      end
      // Runs on whether selected or not; the net run is stale inside this block
      if (bcnt != 0 && !susp) begin
         bcnt--;
         if (bcnt == 0) complete();
      end
      acc = (!chip_select_n && !output_enable_n && write_enable_n && reset_powerdown_n)
            ? acc + 1 : 0;
      // Undriven lines toggle so a stale value never reads as valid
      data_lines_in <= data_lines_oe ? data_lines_out :
         (acc > ACC_CYC ? rdval(address_lines) : ~data_lines_in);
   end
endmodule : flbci_flash_model

// file: dv/flbci_host_monitor.sv
`timescale 1ns/1ps
module flbci_host_monitor
   import flbci_pkg::*;
(
   input wire logic        clock,
   input wire logic        reset,
   input wire logic        cmd_valid,
   input wire logic        cmd_ready,
   input wire logic [3:0]  cmd_op,
   input wire logic [18:0] address_lines,
   input wire logic [15:0] data_lines_out,
   input wire logic        data_lines_oe,
   input wire logic        chip_select_n,
   input wire logic        output_enable_n,
   input wire logic        write_enable_n,
   input wire logic        reset_powerdown_n
);
   // Pin run lengths; no reset, so a second reset keeps the low count going
   int lo_cnt = 0;
   int hi_cnt = 0;
   always_ff @(posedge clock) begin
      lo_cnt <= reset_powerdown_n ? 0 : lo_cnt + 1;
      hi_cnt <= reset_powerdown_n ? hi_cnt + 1 : 0;
   end
   default clocking @(posedge clock);
   endclocking
   default disable iff (reset);
   ////////////////////////////////////////////////////////////////////////////////
   we_oe_excl_a: assert property (!(!write_enable_n && !output_enable_n))
      else $error("write and output enable low together");
   read_ctrl_a: assert property (!output_enable_n |->
      !chip_select_n && write_enable_n && reset_powerdown_n && !data_lines_oe)
      else $error("read strobe without proper qualifiers");
   write_ce_a: assert property (!write_enable_n |->
      !chip_select_n && data_lines_oe && reset_powerdown_n)
      else $error("write strobe without select or data");
   we_first_a: assert property ($rose(write_enable_n) |->
      !chip_select_n && $stable(address_lines))
      else $error("write edge not inside select");
   wr_hold_a: assert property (!write_enable_n && $past(!write_enable_n) |->
      $stable(address_lines) && $stable(data_lines_out))
      else $error("address or data moved under write strobe");
   pd_width_a: assert property ($rose(reset_powerdown_n) |-> lo_cnt >= PD_PULSE_CYC)
      else $error("power-down pulse too short");
   wake_wait_a: assert property ($fell(write_enable_n) |-> hi_cnt >= WAKE_CYC)
      else $error("write too soon after wake");
   pd_start_a: assert property (cmd_valid && cmd_ready && cmd_op == 4'h8
      |-> ##[1:3] !reset_powerdown_n)
      else $error("power-down request not applied");
   one_op_a: assert property (cmd_valid && cmd_ready |=> !cmd_ready)
      else $error("second request taken at once");
endmodule : flbci_host_monitor

bind flbci_host flbci_host_monitor u_mon (.clock, .reset, .cmd_valid, .cmd_ready, .cmd_op,
   .address_lines, .data_lines_out, .data_lines_oe, .chip_select_n, .output_enable_n,
   .write_enable_n, .reset_powerdown_n);

// file: hdl/flbci_bus_if.sv
`timescale 1ns/1ps
interface flbci_bus_if;
   logic        req;
   logic        wr;
   logic [18:0] addr;
   logic [15:0] wdata;
   logic        done;
   logic [15:0] rdata;

   modport ctrl (output req, output wr, output addr, output wdata, input done, input rdata);
   modport eng  (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface : flbci_bus_if

// file: hdl/flbci_cycle.sv
`timescale 1ns/1ps
module flbci_cycle
   import flbci_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        reset,
   flbci_bus_if.eng         bus,
   input  wire logic [15:0] data_lines_in,
   output logic      [18:0] address_lines,
   output logic      [15:0] data_lines_out,
   output logic             data_lines_oe,
   output logic             chip_select_n,
   output logic             output_enable_n,
   output logic             write_enable_n
);

   typedef enum logic [1:0] {E_IDLE, E_SETUP, E_STROBE, E_RECOVER} flbci_eng_t;

   flbci_eng_t  state;
   logic        is_write;
   logic [4:0]  count;
   logic [15:0] data_meta;
   logic [15:0] data_sync;
   logic        count_zero;

   assign count_zero = (count == 5'h00);

   ////////////////////////////////////////////////////////////////////////////////
   // Data lines come from another chip: two stages before use
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         data_meta <= 16'h0000;
         data_sync <= 16'h0000;
      end else begin
         data_meta <= data_lines_in;
         data_sync <= data_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // One bus cycle per request; OE and WE are never low together
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state           <= E_IDLE;
         is_write        <= 1'b0;
         count           <= 5'h00;
         address_lines   <= 19'h00000;
         data_lines_out  <= 16'h0000;
         data_lines_oe   <= 1'b0;
         chip_select_n   <= 1'b1;
         output_enable_n <= 1'b1;
         write_enable_n  <= 1'b1;
         bus.done        <= 1'b0;
         bus.rdata       <= 16'h0000;
      end else begin
         bus.done <= 1'b0;
         case (state)
            E_IDLE: begin
               if (bus.req) begin
                  is_write       <= bus.wr;
                  address_lines  <= bus.addr;
                  data_lines_out <= bus.wdata;
                  data_lines_oe  <= bus.wr;
                  chip_select_n  <= 1'b0;
                  state          <= E_SETUP;
               end
            end
            E_SETUP: begin
               if (is_write) begin
                  write_enable_n <= 1'b0;
                  count          <= 5'(WE_PULSE_CYC - 1);
               end else begin
                  output_enable_n <= 1'b0;
                  count           <= 5'(READ_WAIT_CYC - 1);
               end
               state <= E_STROBE;
            end
            E_STROBE: begin
               if (count_zero) begin
                  // WE rises before CE so WE's edge latches the word
                  write_enable_n  <= 1'b1;
                  output_enable_n <= 1'b1;
                  if (!is_write) begin
                     bus.rdata <= data_sync;
                  end
                  state <= E_RECOVER;
               end else begin
                  count <= count - 5'h01;
               end
            end
            E_RECOVER: begin
               // CE rises one cycle later, data held across the WE edge
               chip_select_n <= 1'b1;
               data_lines_oe <= 1'b0;
               bus.done      <= 1'b1;
               state         <= E_IDLE;
            end
            default: state <= E_IDLE;
         endcase
      end
   end

endmodule : flbci_cycle

// file: hdl/flbci_host.sv
`timescale 1ns/1ps
// Functional notes
// - Setup write then confirm or data write
// - Read with CE, OE low, WE, reset high
// - Power-down: reset input low at least 100 ns
// - No command before wake-to-write time elapses
// - Write only with WE and CE active
// - Erase and write carry target addresses
// - Word write setup codes 40h or 10h
// - Erase setup 20h then confirm d0h
module flbci_host
   import flbci_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        reset,
   input  wire logic        cmd_valid,
   output logic             cmd_ready,
   input  wire logic [3:0]  cmd_op,
   input  wire logic [18:0] cmd_addr,
   input  wire logic [15:0] cmd_data,
   output logic             resp_valid,
   output logic      [15:0] resp_data,
   output logic             flash_busy,
   output logic             powered_down,
   output logic      [18:0] address_lines,
   output logic      [15:0] data_lines_out,
   output logic             data_lines_oe,
   input  wire logic [15:0] data_lines_in,
   output logic             chip_select_n,
   output logic             output_enable_n,
   output logic             write_enable_n,
   output logic             reset_powerdown_n,
   input  wire logic        ready_busy_n
);

   typedef enum logic [2:0] {
      M_PD_HOLD,
      M_WAKE,
      M_IDLE,
      M_FIRST,
      M_SECOND,
      M_READ,
      M_WAIT
   } flbci_state_t;

   flbci_state_t state;
   flbci_state_t after_wait;
   flbci_op_t    op;
   logic [18:0]  addr;
   logic [15:0]  wdata;
   logic [8:0]   count;
   logic         rb_meta;
   logic         rb_sync;

   // Engine handshake: one request pulse in, one done pulse out per bus cycle
   flbci_bus_if  bus ();

   ////////////////////////////////////////////////////////////////////////////////
   // Ready/busy arrives from the device: two stages before use
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         rb_meta <= 1'b1;
         rb_sync <= 1'b1;
      end else begin
         rb_meta <= ready_busy_n;
         rb_sync <= rb_meta;
      end
   end

   assign flash_busy = ~rb_sync;

   ////////////////////////////////////////////////////////////////////////////////
   // Operation decode
   wire       op_is_read    = (op == OP_READ_ARRAY) || (op == OP_READ_STATUS)
                              || (op == OP_READ_ID);
   wire       op_two_writes = (op == OP_WORD_WRITE) || (op == OP_BLOCK_ERASE);
   wire       accept        = cmd_valid && cmd_ready;
   wire       count_zero    = (count == 9'h000);

   // Every read is preceded by its mode command, so the host never tracks
   // which read mode the device was left in; this costs one write cycle
   wire [15:0] first_code =
      (op == OP_READ_ARRAY)   ? CODE_READ_ARRAY   :
      (op == OP_READ_STATUS)  ? CODE_READ_STATUS  :
      (op == OP_READ_ID)      ? CODE_READ_ID      :
      (op == OP_WORD_WRITE)   ? CODE_WRITE_SETUP  :
      (op == OP_BLOCK_ERASE)  ? CODE_ERASE_SETUP  :
      (op == OP_CLEAR_STATUS) ? CODE_CLEAR_STATUS :
      (op == OP_SUSPEND)      ? CODE_SUSPEND      : CODE_CONFIRM;

   // Erase confirm carries the code, word write carries the user's word
   wire [15:0] second_data = (op == OP_WORD_WRITE) ? wdata : CODE_CONFIRM;

   // Commands are accepted only once the wake interval is over
   assign cmd_ready    = (state == M_IDLE);
   assign powered_down = ~reset_powerdown_n;

   ////////////////////////////////////////////////////////////////////////////////
   // Command sequencer
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         // Hold the device in reset after our own reset as well
         state             <= M_PD_HOLD;
         after_wait        <= M_IDLE;
         op                <= OP_READ_ARRAY;
         addr              <= 19'h00000;
         wdata             <= 16'h0000;
         count             <= 9'(PD_PULSE_CYC - 1);
         reset_powerdown_n <= 1'b0;
         resp_valid        <= 1'b0;
         resp_data         <= 16'h0000;
         bus.req           <= 1'b0;
         bus.wr            <= 1'b0;
         bus.addr          <= 19'h00000;
         bus.wdata         <= 16'h0000;
      end else begin
         bus.req    <= 1'b0;
         resp_valid <= 1'b0;
         case (state)
            M_PD_HOLD: begin
               // The hold length sets the deep power-down minimum pulse
               if (count_zero) begin
                  reset_powerdown_n <= 1'b1;
                  count             <= 9'(WAKE_CYC - 1);
                  state             <= M_WAKE;
               end else begin
                  count <= count - 9'h001;
               end
            end
            M_WAKE: begin
               if (count_zero) begin
                  state <= M_IDLE;
               end else begin
                  count <= count - 9'h001;
               end
            end
            M_IDLE: begin
               if (accept) begin
                  op    <= flbci_op_t'(cmd_op);
                  addr  <= cmd_addr;
                  wdata <= cmd_data;
                  state <= M_FIRST;
               end
            end
            M_FIRST: begin
               if (op == OP_POWERDOWN) begin
                  // Aborts any running operation in the device
                  reset_powerdown_n <= 1'b0;
                  count             <= 9'(PD_PULSE_CYC - 1);
                  resp_valid        <= 1'b1;
                  state             <= M_PD_HOLD;
               end else begin
                  bus.req    <= 1'b1;
                  bus.wr     <= 1'b1;
                  bus.addr   <= addr;
                  bus.wdata  <= first_code;
                  after_wait <= op_two_writes ? M_SECOND : (op_is_read ? M_READ : M_IDLE);
                  state      <= M_WAIT;
               end
            end
            M_SECOND: begin
               bus.req    <= 1'b1;
               bus.wr     <= 1'b1;
               bus.addr   <= addr;
               bus.wdata  <= second_data;
               after_wait <= M_IDLE;
               state      <= M_WAIT;
            end
            M_READ: begin
               bus.req    <= 1'b1;
               bus.wr     <= 1'b0;
               bus.addr   <= addr;
               after_wait <= M_IDLE;
               state      <= M_WAIT;
            end
            M_WAIT: begin
               // Only the last bus cycle of an operation answers the user
               if (bus.done) begin
                  state <= after_wait;
                  if (after_wait == M_IDLE) begin
                     resp_valid <= 1'b1;
                     resp_data  <= bus.rdata;
                  end
               end
            end
            default: state <= M_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Pin-level bus cycles
   // Strobes stay registered here, so no glitch reaches the device pins
   flbci_cycle u_cycle (
      .clock           (clock),
      .reset           (reset),
      .bus             (bus.eng),
      .data_lines_in   (data_lines_in),
      .address_lines   (address_lines),
      .data_lines_out  (data_lines_out),
      .data_lines_oe   (data_lines_oe),
      .chip_select_n   (chip_select_n),
      .output_enable_n (output_enable_n),
      .write_enable_n  (write_enable_n)
   );

endmodule : flbci_host

// file: hdl/flbci_pkg.sv
package flbci_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Clock and timing
   localparam int CLOCK_PERIOD_PS   = 5000;
   localparam int PD_PULSE_NS       = 100;
   localparam int WAKE_TO_WRITE_NS  = 1000;
   localparam int WE_PULSE_NS       = 50;
   localparam int READ_ACCESS_NS    = 120;
   localparam int SYNC_STAGES       = 2;

   // Least times round up to whole cycles
   localparam int PD_PULSE_CYC      = (PD_PULSE_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
   localparam int WAKE_CYC          = (WAKE_TO_WRITE_NS * 1000 + CLOCK_PERIOD_PS - 1)
                                      / CLOCK_PERIOD_PS;
   localparam int WE_PULSE_CYC      = (WE_PULSE_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
   localparam int READ_WAIT_CYC     = (READ_ACCESS_NS * 1000 + CLOCK_PERIOD_PS - 1)
                                      / CLOCK_PERIOD_PS + SYNC_STAGES;

   ////////////////////////////////////////////////////////////////////////////////
   // Widths
   localparam int ADDR_W = 19;
   localparam int DATA_W = 16;

   ////////////////////////////////////////////////////////////////////////////////
   // Command codes
   localparam logic [15:0] CODE_READ_ARRAY   = 16'h00ff;
   localparam logic [15:0] CODE_READ_ID      = 16'h0090;
   localparam logic [15:0] CODE_READ_STATUS  = 16'h0070;
   localparam logic [15:0] CODE_CLEAR_STATUS = 16'h0050;
   localparam logic [15:0] CODE_ERASE_SETUP  = 16'h0020;
   localparam logic [15:0] CODE_CONFIRM      = 16'h00d0;
   localparam logic [15:0] CODE_WRITE_SETUP  = 16'h0040;
   localparam logic [15:0] CODE_WRITE_ALT    = 16'h0010;
   localparam logic [15:0] CODE_SUSPEND      = 16'h00b0;

   ////////////////////////////////////////////////////////////////////////////////
   // Memory map and identifier addresses
   localparam logic [18:0] TOP_BOOT_BASE     = 19'h7f000;
   localparam logic [18:0] TOP_PARAM_BASE    = 19'h78000;
   localparam logic [18:0] TOP_MAIN_LIMIT    = 19'h77fff;
   localparam logic [18:0] ID_MAKER_ADDR     = 19'h00000;
   localparam logic [18:0] ID_DEVICE_ADDR    = 19'h00001;

   ////////////////////////////////////////////////////////////////////////////////
   // User operations
   typedef enum logic [3:0] {
      OP_READ_ARRAY,
      OP_READ_STATUS,
      OP_READ_ID,
      OP_WORD_WRITE,
      OP_BLOCK_ERASE,
      OP_CLEAR_STATUS,
      OP_SUSPEND,
      OP_RESUME,
      OP_POWERDOWN
   } flbci_op_t;

endpackage : flbci_pkg
